// ---- tm2_pkg.sv ----
// Contract
// - The two-bit external clock select field picks one external source shared by both bytes.
// - Per-byte clock choice bits pick, for the low byte and in split mode for the high byte, between the external clock and system clock.
// - Every external source is synchronised to the system clock before it advances the timer.
// - Select code 00 counts on system clock divided by twelve and captures on real-time clock/8.
// - Select code 10 counts on system clock divided by twelve.
// - Select code 11 counts on real-time clock divided by eight.
// - In auto-reload operation the low count byte reloads from the reload-low register.
// - In capture operation each capture event copies the low count byte into reload-low.
// - In auto-reload operation the high count byte reloads from the reload-high register.
// - In capture operation each capture event copies the high count byte into reload-high.
// - The low count register is the low half in 16-bit mode and the low timer in split mode.
// - The high count register is the high half in 16-bit mode and the high timer in split mode.
// - In 16-bit mode the high overflow flag sets when the counter wraps 0xFFFF to 0x0000.
// - The low overflow flag sets on every low byte wrap from 0xFF to 0x00 in any mode.
// - Split enable 0 gives one 16-bit auto-reload counter, 1 gives two 8-bit ones.
// - In split mode run control gates only the high byte; the low byte always counts.
package tm2_pkg;
  // Register addresses in the special function register space
  localparam logic [7:0] TM2_CTRL_ADDR = 8'hC8;
  localparam logic [7:0] TM2_RLL_ADDR = 8'hCA;
  localparam logic [7:0] TM2_RLH_ADDR = 8'hCB;
  localparam logic [7:0] TM2_CNTL_ADDR = 8'hCC;
  localparam logic [7:0] TM2_CNTH_ADDR = 8'hCD;
  // Control register field positions
  localparam int TM2_HOVF_BIT = 7;
  localparam int TM2_LOVF_BIT = 6;
  localparam int TM2_LIEN_BIT = 5;
  localparam int TM2_CAPEN_BIT = 4;
  localparam int TM2_SPLIT_BIT = 3;
  localparam int TM2_RUN_BIT = 2;
  localparam int TM2_XCLK_MSB = 1;
  localparam int TM2_XCLK_LSB = 0;
  // Reset values, byte maximum and unmapped read value
  localparam logic [7:0] TM2_CTRL_RST = 8'h00;
  localparam logic [7:0] TM2_RLL_RST = 8'h00;
  localparam logic [7:0] TM2_RLH_RST = 8'h00;
  localparam logic [7:0] TM2_CNTL_RST = 8'h00;
  localparam logic [7:0] TM2_CNTH_RST = 8'h00;
  localparam logic [7:0] TM2_BYTE_MAX = 8'hFF;
  localparam logic [7:0] TM2_UNMAPPED = 8'h00;
  // External clock select encodings
  localparam logic [1:0] TM2_XCLK_SYS12_RTC = 2'h0;
  localparam logic [1:0] TM2_XCLK_RSVD = 2'h1;
  localparam logic [1:0] TM2_XCLK_SYS12 = 2'h2;
  localparam logic [1:0] TM2_XCLK_RTC = 2'h3;
  // Divider counts
  localparam int TM2_SYS_DIV = 12;
  localparam int TM2_EXT_DIV = 8;
  localparam logic [3:0] TM2_SYS_DIV_LAST = 4'(TM2_SYS_DIV - 1);
  localparam logic [2:0] TM2_EXT_DIV_LAST = 3'(TM2_EXT_DIV - 1);
endpackage

// ---- tm2_tick_if.sv ----
`timescale 1ns/100ps
// Count and capture ticks from the clock source unit
interface tm2_tick_if;
  logic sys12_tick;
  logic rtc8_tick;
  logic osc8_tick;
  modport src (output sys12_tick, output rtc8_tick, output osc8_tick);
  modport dst (input sys12_tick, input rtc8_tick, input osc8_tick);
endinterface

// ---- tm2_clk_src.sv ----
`timescale 1ns/100ps
module tm2_clk_src
  import tm2_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous source pins
  input wire logic i_rtc_clk,
  input wire logic i_osc_clk,
  // Ticks to the timer
  tm2_tick_if.src tk
);
  logic [1:0] pin_in;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] prev_ff;
  logic [1:0] edge_w;
  logic [1:0] div_tick_ff;
  logic [3:0] sys_cnt_ff;
  logic sys_tick_ff;

  assign pin_in = {i_osc_clk, i_rtc_clk};

  // Two-flop synchroniser, edge detect and divide by eight per source
  for (genvar g = 0; g < 2; g++) begin : g_src
    logic [2:0] div_ff;
    always_ff @(posedge i_clk) begin
      sync1_ff[g] <= pin_in[g];
      sync2_ff[g] <= sync1_ff[g];
    end
    assign edge_w[g] = sync2_ff[g] & ~prev_ff[g];
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        prev_ff[g] <= 1'b0;
        div_ff <= 3'h0;
        div_tick_ff[g] <= 1'b0;
      end else begin
        prev_ff[g] <= sync2_ff[g];
        div_ff <= edge_w[g] ? div_ff + 3'h1 : div_ff;
        div_tick_ff[g] <= edge_w[g] && (div_ff == TM2_EXT_DIV_LAST);
      end
    end
  end

  // System clock divided by twelve
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sys_cnt_ff <= 4'h0;
      sys_tick_ff <= 1'b0;
    end else begin
      sys_cnt_ff <= (sys_cnt_ff == TM2_SYS_DIV_LAST) ? 4'h0 : sys_cnt_ff + 4'h1;
      sys_tick_ff <= (sys_cnt_ff == TM2_SYS_DIV_LAST);
    end
  end

  assign tk.sys12_tick = sys_tick_ff;
  assign tk.rtc8_tick = div_tick_ff[0];
  assign tk.osc8_tick = div_tick_ff[1];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_sys12_period;
    sys_tick_ff |=> (!sys_tick_ff)[*8] ##1 (!sys_tick_ff)[*3] ##1 sys_tick_ff;
  endproperty
  a_sys12_period: assert property (p_sys12_period) else $error("sys12 tick period wrong");
  property p_rtc_from_edge;
    div_tick_ff[0] |-> $past(edge_w[0]);
  endproperty
  a_rtc_from_edge: assert property (p_rtc_from_edge) else $error("rtc tick without edge");
endmodule

// ---- tm2_timer.sv ----
`timescale 1ns/100ps
module tm2_timer
  import tm2_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Special function register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Per-byte clock choice from the clock choice register
  input wire logic i_high_byte_clock_choice,
  input wire logic i_low_byte_clock_choice,
  // Asynchronous external sources
  input wire logic i_rtc_clk,
  input wire logic i_osc_clk,
  // Overflow flags and low interrupt enable to the interrupt logic
  output logic o_high_overflow_flag,
  output logic o_low_overflow_flag,
  output logic o_low_irq_enable
);
  logic [7:0] ctrl_ff;
  logic [7:0] rll_ff;
  logic [7:0] rlh_ff;
  logic [7:0] cntl_ff;
  logic [7:0] cnth_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] nxt_rll;
  logic [7:0] nxt_rlh;
  logic [7:0] nxt_cntl;
  logic [7:0] nxt_cnth;
  logic [7:0] nxt_rdata;
  logic [1:0] ext_clock_source_select;
  logic split_enable;
  logic run_control;
  logic capture_enable;
  logic wr_ctrl;
  logic wr_rll;
  logic wr_rlh;
  logic wr_cntl;
  logic wr_cnth;
  logic ext_tick;
  logic cap_trig;
  logic capture;
  logic low_tick;
  logic high_tick;
  logic low_en;
  logic high_en;
  logic low_wrap;
  logic high_wrap;
  logic low_reload;
  logic [7:0] reload_l;
  logic [7:0] reload_h;
  logic [7:0] rd_mux;

  tm2_tick_if tk ();

  // Synchronised and divided external sources
  tm2_clk_src u_src (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_rtc_clk (i_rtc_clk),
    .i_osc_clk (i_osc_clk),
    .tk (tk.src)
  );

  // Control fields
  assign ext_clock_source_select = ctrl_ff[TM2_XCLK_MSB:TM2_XCLK_LSB];
  assign split_enable = ctrl_ff[TM2_SPLIT_BIT];
  assign run_control = ctrl_ff[TM2_RUN_BIT];
  assign capture_enable = ctrl_ff[TM2_CAPEN_BIT];

  // Write decode
  assign wr_ctrl = i_sfr_wr && (i_sfr_addr == TM2_CTRL_ADDR);
  assign wr_rll = i_sfr_wr && (i_sfr_addr == TM2_RLL_ADDR);
  assign wr_rlh = i_sfr_wr && (i_sfr_addr == TM2_RLH_ADDR);
  assign wr_cntl = i_sfr_wr && (i_sfr_addr == TM2_CNTL_ADDR);
  assign wr_cnth = i_sfr_wr && (i_sfr_addr == TM2_CNTH_ADDR);

  // One external source shared by both bytes; codes 00, 01, 10 use sys/12
  assign ext_tick = (ext_clock_source_select == TM2_XCLK_RTC) ? tk.rtc8_tick
                  : tk.sys12_tick;
  // Capture trigger: rtc/8 for codes 00 and 01, oscillator/8 otherwise
  assign cap_trig = ((ext_clock_source_select == TM2_XCLK_SYS12_RTC) ||
                     (ext_clock_source_select == TM2_XCLK_RSVD)) ? tk.rtc8_tick
                    : tk.osc8_tick;
  assign capture = capture_enable && cap_trig;

  // Per-byte choice between external ticks and every system clock
  assign low_tick = i_low_byte_clock_choice ? 1'b1 : ext_tick;
  assign high_tick = i_high_byte_clock_choice ? 1'b1 : ext_tick;

  // Count enables: split lets low run free and gates high by run
  assign low_en = split_enable ? low_tick : (run_control && low_tick);
  assign low_wrap = low_en && (cntl_ff == TM2_BYTE_MAX);
  assign high_en = split_enable ? (run_control && high_tick) : low_wrap;
  assign high_wrap = high_en && (cnth_ff == TM2_BYTE_MAX);
  // In 16-bit mode the low byte reloads only on a full wrap
  assign low_reload = split_enable ? low_wrap : high_wrap;

  // Reload values; in capture operation the byte wraps to zero
  assign reload_l = capture_enable ? TM2_CNTL_RST : rll_ff;
  assign reload_h = capture_enable ? TM2_CNTH_RST : rlh_ff;

  // Next count values; a processor write wins over counting
  assign nxt_cntl = wr_cntl ? i_sfr_wdata
                  : low_reload ? reload_l
                  : low_en ? cntl_ff + 8'h01
                  : cntl_ff;
  assign nxt_cnth = wr_cnth ? i_sfr_wdata
                  : high_wrap ? reload_h
                  : high_en ? cnth_ff + 8'h01
                  : cnth_ff;

  // Reload registers; a capture event wins over a write
  assign nxt_rll = capture ? cntl_ff
                 : wr_rll ? i_sfr_wdata : rll_ff;
  assign nxt_rlh = capture ? cnth_ff
                 : wr_rlh ? i_sfr_wdata : rlh_ff;

  // Control register; hardware flag sets win over firmware clears
  always_comb begin
    nxt_ctrl = wr_ctrl ? i_sfr_wdata : ctrl_ff;
    if (high_wrap) begin
      nxt_ctrl[TM2_HOVF_BIT] = 1'b1;
    end
    if (low_wrap) begin
      nxt_ctrl[TM2_LOVF_BIT] = 1'b1;
    end
  end

  // Read select; unmapped addresses read zero
  assign rd_mux = (i_sfr_addr == TM2_CTRL_ADDR) ? ctrl_ff
                : (i_sfr_addr == TM2_RLL_ADDR) ? rll_ff
                : (i_sfr_addr == TM2_RLH_ADDR) ? rlh_ff
                : (i_sfr_addr == TM2_CNTL_ADDR) ? cntl_ff
                : (i_sfr_addr == TM2_CNTH_ADDR) ? cnth_ff
                : TM2_UNMAPPED;
  assign nxt_rdata = i_sfr_rd ? rd_mux : TM2_UNMAPPED;

  // Register state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_ff <= TM2_CTRL_RST;
      rll_ff <= TM2_RLL_RST;
      rlh_ff <= TM2_RLH_RST;
      cntl_ff <= TM2_CNTL_RST;
      cnth_ff <= TM2_CNTH_RST;
      rdata_ff <= TM2_UNMAPPED;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rll_ff <= nxt_rll;
      rlh_ff <= nxt_rlh;
      cntl_ff <= nxt_cntl;
      cnth_ff <= nxt_cnth;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flops
  assign o_sfr_rdata = rdata_ff;
  assign o_high_overflow_flag = ctrl_ff[TM2_HOVF_BIT];
  assign o_low_overflow_flag = ctrl_ff[TM2_LOVF_BIT];
  assign o_low_irq_enable = ctrl_ff[TM2_LIEN_BIT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Code 11: without an rtc tick an externally clocked low byte holds
  property p_rtc_hold;
    !i_low_byte_clock_choice && !i_sfr_wr && !tk.rtc8_tick &&
      (ext_clock_source_select == TM2_XCLK_RTC) |=> $stable(cntl_ff);
  endproperty
  a_rtc_hold: assert property (p_rtc_hold) else $error("low byte moved without rtc tick");
  // Code 10: low byte advances by one on a sys/12 tick
  property p_sys12_step;
    (split_enable || run_control) && !i_low_byte_clock_choice && !i_sfr_wr && tk.sys12_tick &&
      (cntl_ff != TM2_BYTE_MAX) && (ext_clock_source_select == TM2_XCLK_SYS12)
      |=> cntl_ff == $past(cntl_ff) + 8'h01;
  endproperty
  a_sys12_step: assert property (p_sys12_step) else $error("sys12 tick did not count");
  // System clock choice counts every cycle
  property p_system_clock_choice;
    split_enable && i_low_byte_clock_choice && !i_sfr_wr ##1 !$past(low_wrap)
      |-> cntl_ff == $past(cntl_ff) + 8'h01;
  endproperty
  a_system_clock_choice: assert property (p_system_clock_choice) else $error("choice bit ignored");
  // Capture with code 00 copies both bytes
  property p_capture_00;
    capture_enable && tk.rtc8_tick && (ext_clock_source_select == TM2_XCLK_SYS12_RTC)
      |=> (rll_ff == $past(cntl_ff)) && (rlh_ff == $past(cnth_ff));
  endproperty
  a_capture_00: assert property (p_capture_00) else $error("capture missed");
  // Reserved code captures like code 00
  property p_capture_01;
    capture_enable && tk.rtc8_tick && (ext_clock_source_select == TM2_XCLK_RSVD)
      |=> rll_ff == $past(cntl_ff);
  endproperty
  a_capture_01: assert property (p_capture_01) else $error("reserved code differs");
  // Split low wrap reloads from reload-low
  property p_low_reload;
    split_enable && !capture_enable && low_wrap && !i_sfr_wr |=> cntl_ff == $past(rll_ff);
  endproperty
  a_low_reload: assert property (p_low_reload) else $error("low reload wrong");
  // High wrap reloads from reload-high
  property p_high_reload;
    !capture_enable && high_wrap && !i_sfr_wr |=> cnth_ff == $past(rlh_ff);
  endproperty
  a_high_reload: assert property (p_high_reload) else $error("high reload wrong");
  // 16-bit wrap sets high flag and keeps it until a write
  property p_full_wrap_flag;
    !split_enable && high_wrap |=> o_high_overflow_flag ##1 o_high_overflow_flag || $past(wr_ctrl);
  endproperty
  a_full_wrap_flag: assert property (p_full_wrap_flag) else $error("high flag not set");
  // Low wrap sets the low flag in any mode
  property p_low_flag;
    low_wrap |=> o_low_overflow_flag;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set");
  // 16-bit mode: high byte holds until the low byte wraps
  property p_carry_only;
    !split_enable && !low_wrap && !i_sfr_wr |=> $stable(cnth_ff);
  endproperty
  a_carry_only: assert property (p_carry_only) else $error("high moved without carry");
  // Split mode with run clear freezes only the high byte
  property p_run_gate;
    split_enable && !run_control && !i_sfr_wr |=> $stable(cnth_ff);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("high ran while stopped");
  // Count registers read back one cycle later
  property p_read_counts;
    i_sfr_rd && (i_sfr_addr == TM2_CNTL_ADDR) ##1 1'b1 |-> o_sfr_rdata == $past(cntl_ff);
  endproperty
  a_read_counts: assert property (p_read_counts) else $error("low count readback wrong");
  property p_read_high;
    i_sfr_rd && (i_sfr_addr == TM2_CNTH_ADDR) |=> o_sfr_rdata == $past(cnth_ff);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high count readback wrong");
  // Shared select drives both bytes in split mode
  property p_shared_select;
    split_enable && run_control && !i_low_byte_clock_choice && !i_high_byte_clock_choice &&
      !i_sfr_wr && !ext_tick |=> $stable(cntl_ff) && $stable(cnth_ff);
  endproperty
  a_shared_select: assert property (p_shared_select) else $error("byte counted alone");
  // Capture wins over a reload-low write
  property p_capture_wins_low;
    capture && wr_rll |=> rll_ff == $past(cntl_ff);
  endproperty
  a_capture_wins_low: assert property (p_capture_wins_low) else $error("write beat capture");
  // Capture wins over a reload-high write
  property p_capture_wins_high;
    capture && wr_rlh |=> rlh_ff == $past(cnth_ff);
  endproperty
  a_capture_wins_high: assert property (p_capture_wins_high) else $error("write beat capture");
  // High flag only changes on a wrap or a control write
  property p_high_flag_hold;
    !high_wrap && !wr_ctrl |=> $stable(o_high_overflow_flag);
  endproperty
  a_high_flag_hold: assert property (p_high_flag_hold) else $error("high flag moved");
  // Low flag only changes on a wrap or a control write
  property p_low_flag_hold;
    !low_wrap && !wr_ctrl |=> $stable(o_low_overflow_flag);
  endproperty
  a_low_flag_hold: assert property (p_low_flag_hold) else $error("low flag moved");
  // In capture operation a low reload goes to zero
  property p_capture_wrap_zero;
    capture_enable && low_reload && !wr_cntl |=> cntl_ff == TM2_CNTL_RST;
  endproperty
  a_capture_wrap_zero: assert property (p_capture_wrap_zero) else $error("capture wrap wrong");
  // Split mode low byte counts on its tick whatever the run bit
  property p_split_low_free;
    split_enable && low_tick && !wr_cntl && !low_wrap |=> cntl_ff == $past(cntl_ff) + 8'h01;
  endproperty
  a_split_low_free: assert property (p_split_low_free) else $error("low byte stalled");
  // Read data returns to zero without a read
  property p_rdata_idle;
    !i_sfr_rd |=> o_sfr_rdata == TM2_UNMAPPED;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  // 16-bit full wrap reloads the low byte from reload-low
  property p_full_reload_low;
    !split_enable && !capture_enable && high_wrap && !wr_cntl |=> cntl_ff == $past(rll_ff);
  endproperty
  a_full_reload_low: assert property (p_full_reload_low) else $error("full reload wrong");
  // Code 11 with external choice steps the low byte on rtc ticks
  property p_rtc_select;
    (ext_clock_source_select == TM2_XCLK_RTC) && !i_low_byte_clock_choice |-> low_tick == tk.rtc8_tick;
  endproperty
  a_rtc_select: assert property (p_rtc_select) else $error("rtc select wrong");

  c_split_low_wrap: cover property (split_enable && low_wrap);
  c_full_wrap: cover property (!split_enable && high_wrap);
  c_capture: cover property (capture);
  c_rtc_count: cover property ((ext_clock_source_select == TM2_XCLK_RTC) && low_en);
  c_full_reload: cover property (!split_enable && !capture_enable && high_wrap);
endmodule

// ---- tm2_cpu_model.sv ----
`timescale 1ns/100ps
// Processor core side of the special function register bus
module tm2_cpu_model (
  // Clock
  input wire logic i_clk,
  // Register bus toward the timer
  output logic [7:0] o_sfr_addr,
  output logic o_sfr_wr,
  output logic o_sfr_rd,
  output logic [7:0] o_sfr_wdata,
  input wire logic [7:0] i_sfr_rdata
);
  // Bus idles with both strobes low from time zero
  initial begin
    o_sfr_addr = 8'h00;
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_wdata = 8'h00;
  end

  // One-cycle write strobe; address and data held through the taking edge
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_sfr_addr <= addr;
    o_sfr_wdata <= data;
    o_sfr_wr <= 1'b1;
    @(posedge i_clk);
    o_sfr_wr <= 1'b0;
    o_sfr_wdata <= ~data;  // Released data stops showing the last value
  endtask

  // One-cycle read strobe; data stands for one cycle and is taken at the next edge
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clk);
    o_sfr_addr <= addr;
    o_sfr_rd <= 1'b1;
    @(posedge i_clk);
    o_sfr_rd <= 1'b0;
    @(posedge i_clk);
    data = i_sfr_rdata;
  endtask
endmodule

// ---- tb_tm2_timer.sv ----
`timescale 1ns/100ps
module tb_tm2_timer;
  import tm2_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic rtc_clk = 1'b0;
  logic osc_clk = 1'b0;
  logic hi_choice = 1'b1;
  logic lo_choice = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, hovf, lovf, lien;
  logic [1:0] flags;
  logic [7:0] lfsr = 8'h5C;
  logic [7:0] d, a, b, h;
  int fail_count = 0;
  int cmp_count = 0;

  // System clock, 8 ns period
  always #4 i_clk = ~i_clk;
  // Real-time clock pin, 40 ns period, offset from the system clock
  initial begin
    #3;
    forever #20 rtc_clk = ~rtc_clk;
  end

  tm2_cpu_model i_cpu (.i_clk(i_clk), .o_sfr_addr(sfr_addr), .o_sfr_wr(sfr_wr),
    .o_sfr_rd(sfr_rd), .o_sfr_wdata(sfr_wdata), .i_sfr_rdata(sfr_rdata));
  tm2_timer i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
    .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
    .i_high_byte_clock_choice(hi_choice), .i_low_byte_clock_choice(lo_choice),
    .i_rtc_clk(rtc_clk), .i_osc_clk(osc_clk), .o_high_overflow_flag(hovf),
    .o_low_overflow_flag(lovf), .o_low_irq_enable(lien));

  // Eight-bit shift register random source
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected external ticks over a run of so many edges
  function automatic logic [7:0] exp_ticks(input int edges, input logic [1:0] code);
    return (code == TM2_XCLK_RTC) ? 8'(edges / (5 * TM2_EXT_DIV)) : 8'(edges / TM2_SYS_DIV);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    i_cpu.read(addr, d);
    chk(d, exp);
  endtask

  // Run for n counting edges, noting the flags just before stopping
  task automatic run_for(input int n, input logic [7:0] ctrl);
    i_cpu.write(TM2_CTRL_ADDR, ctrl | 8'h04);
    repeat (n - 2) @(posedge i_clk);
    flags = {hovf, lovf};
    i_cpu.write(TM2_CTRL_ADDR, ctrl);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog for a hung bus or handshake
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values and unmapped read
    rd_chk(TM2_CTRL_ADDR, TM2_CTRL_RST);
    for (int r = 0; r < 4; r++) begin
      rd_chk(8'(TM2_RLL_ADDR + r), 8'h00);
    end
    i_cpu.write(8'hC9, 8'hA5);
    rd_chk(8'hC9, TM2_UNMAPPED);
    // Random write and read back while stopped
    for (int r = 0; r < 4; r++) begin
      lfsr = next_rand(lfsr);
      i_cpu.write(8'(TM2_RLL_ADDR + r), lfsr);
      rd_chk(8'(TM2_RLL_ADDR + r), lfsr);
    end
    // 16-bit wrap from 0xFFFD with reload
    lfsr = next_rand(lfsr);
    a = lfsr & 8'h7F;
    lfsr = next_rand(lfsr);
    b = lfsr;
    i_cpu.write(TM2_RLL_ADDR, a);
    i_cpu.write(TM2_RLH_ADDR, b);
    i_cpu.write(TM2_CNTL_ADDR, 8'hFD);
    i_cpu.write(TM2_CNTH_ADDR, 8'hFF);
    run_for(6, 8'h00);
    chk({6'h00, flags}, 8'h03);
    rd_chk(TM2_CNTL_ADDR, 8'(a + 3));
    rd_chk(TM2_CNTH_ADDR, b);
    // Split mode: low runs free, high waits for run control
    lfsr = next_rand(lfsr);
    h = lfsr & 8'h7F;
    i_cpu.write(TM2_CNTH_ADDR, h);
    i_cpu.write(TM2_CTRL_ADDR, 8'h08);
    repeat (300) @(posedge i_clk);
    chk({7'h00, lovf}, 8'h01);
    rd_chk(TM2_CNTH_ADDR, h);
    i_cpu.read(TM2_CNTL_ADDR, d);
    chk({7'h00, d >= a}, 8'h01);
    run_for(10, 8'h08);
    rd_chk(TM2_CNTH_ADDR, 8'(h + 10));
    // External clock codes on the low byte
    @(posedge i_clk);
    lo_choice <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      i_cpu.write(TM2_CNTL_ADDR, 8'h00);
      i_cpu.write(TM2_CNTH_ADDR, 8'h00);
      run_for(360, 8'(c));
      rd_chk(TM2_CNTL_ADDR, exp_ticks(360, 2'(c)));
    end
    // Capture on the real-time trigger while the count is frozen
    @(posedge i_clk);
    lo_choice <= 1'b1;
    i_cpu.write(TM2_CNTL_ADDR, a ^ 8'h3C);
    i_cpu.write(TM2_CNTH_ADDR, b ^ 8'hC3);
    i_cpu.write(TM2_CTRL_ADDR, 8'h10);
    repeat (100) @(posedge i_clk);
    rd_chk(TM2_RLL_ADDR, a ^ 8'h3C);
    rd_chk(TM2_RLH_ADDR, b ^ 8'hC3);
    finish_test();
  end
endmodule
